// ==== rtl/scss_params.svh ====
// constants for the system clock source select block
// assumes the sfr bus carries 8-bit addresses and 8-bit data
`ifndef SCSS_PARAMS_SVH
`define SCSS_PARAMS_SVH

// ==========================================================
// sfr addresses
`define SCSS_ADDR_INT_OSC_CTRL  8'h8a
`define SCSS_ADDR_EXT_OSC_CTRL  8'h8c
`define SCSS_ADDR_CLK_SRC_SEL   8'h8f

// ==========================================================
// reset values
`define SCSS_RST_INT_OSC_CTRL   8'hc0
`define SCSS_RST_EXT_OSC_CTRL   8'h00
`define SCSS_RST_CLK_SRC_SEL    8'h00

// ==========================================================
// field positions
`define SCSS_BIT_INT_EN         7
`define SCSS_BIT_INT_RDY        6
`define SCSS_BIT_XTAL_VALID     7
`define SCSS_MODE_HI            6
`define SCSS_MODE_LO            4
`define SCSS_FREQ_HI            2
`define SCSS_FREQ_LO            0
`define SCSS_DIV_HI             1
`define SCSS_DIV_LO             0
`define SCSS_BIT_CLK_SRC        0

`endif

// ==== rtl/scss_pkg.sv ====
// types shared by the system clock source select block
// assumes nothing beyond a systemverilog compiler
`default_nettype none

package scss_pkg;

  // ========================================================
  // external oscillator mode codes
  typedef enum logic [2:0]
  {
    SCSS_XM_OFF0     = 3'b000,
    SCSS_XM_OFF1     = 3'b001,
    SCSS_XM_CMOS     = 3'b010,
    SCSS_XM_CMOS_D2  = 3'b011,
    SCSS_XM_RC0      = 3'b100,
    SCSS_XM_RC1      = 3'b101,
    SCSS_XM_XTAL     = 3'b110,
    SCSS_XM_XTAL_D2  = 3'b111
  } scss_xmode_t;

endpackage

`default_nettype wire

// ==== rtl/scss_top.sv ====
// system clock source selection and external oscillator control
// assumes oscillator activity arrives as synchronous ticks or levels
// sampled on clk; the system clock is modelled as a level plus a tick
//
// How it works
// - bit 0 picks internal divided or external
// - external ticks always reach peripherals
// - source may change on the fly
// - internal enable takes effect in one write
// - crystal valid flag set once crystal stable
// - mode field decodes off, cmos, rc, crystal
// - external control bit 3 reads zero
// - three-bit frequency field drives range
// - rc and c modes need no settling
// - divider field 00..11 gives 8,4,2,1
// - internal enable bit, internal clock after reset
`include "scss_params.svh"
`default_nettype none

module scss_top
  import scss_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // sfr bus
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  // oscillator sources
  input  wire logic       int_osc_tick,
  input  wire logic       osc_pin_one,
  input  wire logic       xtal_amp_ok,
  // analog controls
  output logic            int_osc_enable,
  output logic      [2:0] ext_osc_mode,
  output logic      [2:0] ext_freq_control,
  // clocks out
  output logic            system_clock,
  output logic            system_clock_tick,
  output logic            periph_ext_tick
);

  // ========================================================
  // reset release
  logic rst_meta_reg;     // first stage, read only by the second
  logic rst_sync_reg;     // synchronised active-low reset copy
  logic rst_n;

  // async assert, two-flop release
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_sync_reg;

  // ========================================================
  // registers
  logic        int_en_reg,   int_en_next;    // internal osc enable
  logic [1:0]  div_sel_reg,  div_sel_next;   // internal divider field
  scss_xmode_t xmode_reg,    xmode_next;     // external mode field
  logic [2:0]  xfreq_reg,    xfreq_next;     // external frequency field
  logic        src_sel_reg,  src_sel_next;   // requested clock source
  logic [7:0]  rdata_reg,    rdata_next;     // read data
  logic        xtal_mode;                    // mode 11x
  logic        xvalid_reg,   xvalid_next;    // crystal valid flag

  assign xtal_mode = (xmode_reg[2:1] == 2'b11);

  // register writes and reads
  always_comb
  begin
    int_en_next  = int_en_reg;
    div_sel_next = div_sel_reg;
    xmode_next   = xmode_reg;
    xfreq_next   = xfreq_reg;
    src_sel_next = src_sel_reg;
    rdata_next   = rdata_reg;
    if (sfr_wr)
    begin
      case (sfr_addr)
        `SCSS_ADDR_INT_OSC_CTRL:
        begin
          int_en_next  = sfr_wdata[`SCSS_BIT_INT_EN];
          div_sel_next = sfr_wdata[`SCSS_DIV_HI:`SCSS_DIV_LO];
        end
        `SCSS_ADDR_EXT_OSC_CTRL:
        begin
          // bit 7 is read only, bit 3 is dropped
          xmode_next = scss_xmode_t'(sfr_wdata[`SCSS_MODE_HI:`SCSS_MODE_LO]);
          xfreq_next = sfr_wdata[`SCSS_FREQ_HI:`SCSS_FREQ_LO];
        end
        `SCSS_ADDR_CLK_SRC_SEL:
        begin
          src_sel_next = sfr_wdata[`SCSS_BIT_CLK_SRC];
        end
        default:
        begin
          // other sfrs are not ours
        end
      endcase
    end
    if (sfr_rd)
    begin
      case (sfr_addr)
        `SCSS_ADDR_INT_OSC_CTRL:
          // ready mirrors enable: internal osc needs no start-up
          rdata_next = {int_en_reg, int_en_reg, 4'h0, div_sel_reg};
        `SCSS_ADDR_EXT_OSC_CTRL:
          rdata_next = {xvalid_reg, xmode_reg, 1'b0, xfreq_reg};
        `SCSS_ADDR_CLK_SRC_SEL:
          rdata_next = {7'h00, src_sel_reg};
        default:
          rdata_next = 8'h00;
      endcase
    end
  end

  // hold register state
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      int_en_reg  <= 1'(`SCSS_RST_INT_OSC_CTRL >> `SCSS_BIT_INT_EN);
      div_sel_reg <= 2'(`SCSS_RST_INT_OSC_CTRL & 8'h03);
      xmode_reg   <= SCSS_XM_OFF0;
      xfreq_reg   <= 3'(`SCSS_RST_EXT_OSC_CTRL & 8'h07);
      src_sel_reg <= 1'(`SCSS_RST_CLK_SRC_SEL & 8'h01);
      rdata_reg   <= 8'h00;
    end
    else
    begin
      int_en_reg  <= int_en_next;
      div_sel_reg <= div_sel_next;
      xmode_reg   <= xmode_next;
      xfreq_reg   <= xfreq_next;
      src_sel_reg <= src_sel_next;
      rdata_reg   <= rdata_next;
    end
  end

  // ========================================================
  // internal divider
  logic [2:0] div_cnt_reg, div_cnt_next;   // tick counter
  logic [2:0] div_term;                    // last count of a period
  logic       int_tick;                    // divided internal tick

  // terminal count from the divider field
  always_comb
  begin
    case (div_sel_reg)
      2'b00:   div_term = 3'd7;
      2'b01:   div_term = 3'd3;
      2'b10:   div_term = 3'd1;
      default: div_term = 3'd0;
    endcase
    // enabled oscillator ticks at once, no settle wait
    int_tick     = int_en_reg && int_osc_tick && (div_cnt_reg >= div_term);
    div_cnt_next = div_cnt_reg;
    if (int_en_reg && int_osc_tick)
    begin
      div_cnt_next = (div_cnt_reg >= div_term) ? 3'd0 : div_cnt_reg + 3'd1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      div_cnt_reg <= 3'd0;
    else
      div_cnt_reg <= div_cnt_next;
  end

  // ========================================================
  // external oscillator
  logic pin_prev_reg;              // last pin sample
  logic half_reg,   half_next;     // divide-by-2 phase
  logic pin_rise;
  logic ext_tick;                  // external osc tick after mode

  always_comb
  begin
    pin_rise  = osc_pin_one && !pin_prev_reg;
    half_next = half_reg;
    ext_tick  = 1'b0;
    case (xmode_reg)
      SCSS_XM_CMOS, SCSS_XM_XTAL:
        ext_tick = pin_rise;
      SCSS_XM_CMOS_D2, SCSS_XM_RC0, SCSS_XM_RC1, SCSS_XM_XTAL_D2:
      begin
        // rc and c run without settling; the halving stage drops every other edge
        ext_tick = pin_rise && half_reg;
        if (pin_rise)
          half_next = !half_reg;
      end
      default:
        half_next = 1'b0;   // circuit off
    endcase
    // only a running crystal with good amplitude is valid
    xvalid_next = xtal_mode && xtal_amp_ok;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_prev_reg <= 1'b0;
      half_reg     <= 1'b0;
      xvalid_reg   <= 1'b0;
    end
    else
    begin
      pin_prev_reg <= osc_pin_one;
      half_reg     <= half_next;
      xvalid_reg   <= xvalid_next;
    end
  end

  // ========================================================
  // glitch-free source switch
  logic act_sel_reg, act_sel_next;   // source now driving
  logic sys_reg,     sys_next;       // system clock level
  logic stick_reg,   stick_next;     // rising-edge tick
  logic ptick_reg;                   // peripheral ext tick
  logic src_tick;

  // switch only while the clock is low, so no high phase is cut
  always_comb
  begin
    act_sel_next = act_sel_reg;
    sys_next     = sys_reg;
    stick_next   = 1'b0;
    src_tick     = act_sel_reg ? ext_tick : int_tick;
    if (act_sel_reg != src_sel_reg && !sys_reg)
    begin
      act_sel_next = src_sel_reg;
    end
    else if (src_tick)
    begin
      sys_next   = !sys_reg;
      stick_next = !sys_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      act_sel_reg <= 1'b0;
      sys_reg     <= 1'b0;
      stick_reg   <= 1'b0;
      ptick_reg   <= 1'b0;
    end
    else
    begin
      act_sel_reg <= act_sel_next;
      sys_reg     <= sys_next;
      stick_reg   <= stick_next;
      ptick_reg   <= ext_tick;
    end
  end

  // ========================================================
  // outputs, all from flops
  assign sfr_rdata         = rdata_reg;
  assign int_osc_enable    = int_en_reg;
  assign ext_osc_mode      = xmode_reg;
  assign ext_freq_control  = xfreq_reg;
  assign system_clock      = sys_reg;
  assign system_clock_tick = stick_reg;
  assign periph_ext_tick   = ptick_reg;

endmodule

`default_nettype wire

// ==== tb/scss_top_monitor.sv ====
// checker for the clock source select block, watching scss_top ports only
// assumes it is bound to scss_top and sees one clock domain
`default_nettype none

module scss_top_monitor (
  // clock and reset
  input wire logic       clk,
  input wire logic       resetn,
  // sfr bus
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  // oscillator side and outputs
  input wire logic       osc_pin_one,
  input wire logic       int_osc_enable,
  input wire logic [2:0] ext_osc_mode,
  input wire logic       system_clock,
  input wire logic       system_clock_tick,
  input wire logic       periph_ext_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // ====
  // clock outputs
  chk_tick_rise: assert property (system_clock_tick == $rose(system_clock))
    else $error("tick does not match a system clock rise");
  chk_tick_gap: assert property (system_clock_tick |=> system_clock)
    else $error("system clock high phase too short");
  chk_cmos_tick: assert property ((ext_osc_mode == 3'b010) [*2] ##0 $rose(osc_pin_one)
    |-> ##[1:2] periph_ext_tick)
    else $error("pin edge did not reach the peripheral tick");
  chk_ext_off: assert property ((ext_osc_mode[2:1] == 2'b00) [*3] |-> !periph_ext_tick)
    else $error("peripheral tick while external circuit off");

  // ====
  // register effects
  chk_mode_write: assert property (sfr_wr && sfr_addr == 8'h8c
    |=> ext_osc_mode == $past(sfr_wdata[6:4]))
    else $error("mode field not taken from the write");
  chk_int_enable: assert property (sfr_wr && sfr_addr == 8'h8a
    |=> int_osc_enable == $past(sfr_wdata[7]))
    else $error("internal enable not taken from the write");
  chk_bit3_zero: assert property (!sfr_rdata[3])
    else $error("unused bit reads one");
  chk_xtal_flag: assert property ((ext_osc_mode[2:1] != 2'b11) [*2] ##0 (sfr_rd && sfr_addr == 8'h8c)
    |=> !sfr_rdata[7])
    else $error("crystal flag set outside crystal mode");
endmodule

`default_nettype wire

// ==== tb/scss_ext_osc.sv ====
// external oscillator model: square wave on the pin plus amplitude detector
// assumes the mode comes from the device's mode field output
`default_nettype none

module scss_ext_osc #(
  parameter int HALF   = 4,
  parameter int SETTLE = 400
) (
  // clock and control
  input  wire logic       clk,
  input  wire logic [2:0] mode,
  // oscillator side
  output var logic        osc_pin_one,
  output var logic        xtal_amp_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  int ph  = 0; // phase within one pin period
  int age = 0; // cycles since the crystal was enabled
  initial osc_pin_one = 1'b0;
  initial xtal_amp_ok = 1'b0;

  // ====
  // pin stands still while off; rc and c run at once, crystal needs a settle time
  always @(posedge clk)
  begin
    ph <= (mode[2:1] == 2'b00) ? 0 : (ph + 1) % (2 * HALF);
    osc_pin_one <= (mode[2:1] != 2'b00) && (ph >= HALF);
    age <= (mode[2:1] == 2'b11) ? age + 1 : 0;
    xtal_amp_ok <= (mode[2:1] == 2'b11) && (age >= SETTLE);
  end
endmodule

`default_nettype wire

// ==== tb/scss_top_test.sv ====
// self-checking bench for the clock source select block
// assumes scss_top, the oscillator model and the monitor are compiled
`default_nettype none

module scss_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ====
  // bench signals
  logic       clk = 1'b0, resetn = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, int_osc_tick = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00;
  wire logic [7:0] sfr_rdata;
  wire logic [2:0] ext_osc_mode, ext_freq_control;
  wire logic  osc_pin_one, xtal_amp_ok, int_osc_enable, system_clock, system_clock_tick, periph_ext_tick;
  int         error_cnt = 0, n_checks = 0;

  scss_top uut (.clk, .resetn, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .int_osc_tick,
    .osc_pin_one, .xtal_amp_ok, .int_osc_enable, .ext_osc_mode, .ext_freq_control, .system_clock,
    .system_clock_tick, .periph_ext_tick);
  scss_ext_osc osc (.clk, .mode(ext_osc_mode), .osc_pin_one, .xtal_amp_ok);

  // ====
  // clock, and an internal oscillator tick every second cycle
  initial forever #10 clk = ~clk;
  always @(negedge clk) int_osc_tick <= ~int_osc_tick;

  // ====
  // helpers
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    v = sfr_rdata;
  endtask
  // cycles until the next system clock tick, bounded so a stall ends the run
  task automatic tick_wait(output int n);
    n = 1;
    @(negedge clk);
    while (system_clock_tick !== 1'b1)
    begin
      @(negedge clk);
      n++;
      if (n > 600)
      begin
        error_cnt++;
        conclude();
      end
    end
  endtask

  // ====
  // main sequence
  initial
  begin
    logic [7:0] v;
    int n, m;
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    repeat (3) @(negedge clk);
    rd(8'h8a, v); check(v, 8'hc0);
    rd(8'h8c, v); check(v, 8'h00);
    rd(8'h8f, v); check(v, 8'h00);
    wr(8'h8b, 8'hff); rd(8'h8b, v); check(v, 8'h00);
    $display("test reset done");
    for (m = 0; m < 8; m++)
    begin
      wr(8'h8c, {1'b1, m[2:0], 1'b1, 3'(7 - m)});
      rd(8'h8c, v); check(v, {1'b0, m[2:0], 1'b0, 3'(7 - m)});
      check({5'h00, ext_osc_mode}, {5'h00, m[2:0]});
      check({5'h00, ext_freq_control}, {5'h00, 3'(7 - m)});
    end
    $display("test modes done");
    wr(8'h8c, 8'h20);
    wr(8'h8a, 8'h03);
    n = 0;
    repeat (64) @(negedge clk) n += (system_clock_tick === 1'b1);
    check(8'(n), 8'h00);
    for (m = 0; m < 4; m++)
    begin
      wr(8'h8a, {1'b1, 5'h00, m[1:0]});
      tick_wait(n); tick_wait(n); tick_wait(n); check(8'(n), 8'(4 << (3 - m)));
    end
    n = 0;
    repeat (64) @(negedge clk) n += (periph_ext_tick === 1'b1);
    check(8'(n), 8'h08);
    $display("test internal done");
    wr(8'h8c, 8'h67);
    repeat (50000) @(negedge clk);
    n = 0;
    v = 8'h00;
    while (v[7] !== 1'b1 && n < 50)
    begin
      rd(8'h8c, v);
      n++;
    end
    check(v, 8'he7);
    wr(8'h8f, 8'h01);
    tick_wait(n); tick_wait(n); tick_wait(n); check(8'(n), 8'h10);
    wr(8'h8c, 8'h77);
    tick_wait(n); tick_wait(n); tick_wait(n); check(8'(n), 8'h20);
    wr(8'h8f, 8'h00);
    tick_wait(n); tick_wait(n); tick_wait(n); check(8'(n), 8'h04);
    $display("test crystal done");
    conclude();
  end
endmodule

bind scss_top scss_top_monitor mon (.clk, .resetn, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
  .osc_pin_one, .int_osc_enable, .ext_osc_mode, .system_clock, .system_clock_tick, .periph_ext_tick);

`default_nettype wire
